// ---- pkg/pss_defines.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH

`define PSS_OFF_STATUS 12'h000
`define PSS_OFF_CTRL 12'h004
`define PSS_OFF_IRQ_STAT 12'h008
`define PSS_OFF_IRQ_MASK 12'h00c
`define PSS_OFF_LINK_IN 12'h010

`define PSS_BIT_RESOLVED 11
`define PSS_BIT_LINK 10
`define PSS_BIT_XOVER 6
`define PSS_BIT_DOWNGRADE 5
`define PSS_BIT_ENERGY 4
`define PSS_BIT_TX_PAUSE 3
`define PSS_BIT_RX_PAUSE 2

`define PSS_CTRL_XOVER_LO 5
`define PSS_CTRL_XOVER_HI 6
`define PSS_CTRL_SW_RESET 15
`define PSS_CTRL_AN_ENABLE 12

`define PSS_XOVER_MANUAL_MDI 2'h0
`define PSS_XOVER_MANUAL_MDIX 2'h1

`define PSS_IRQ_RESOLVED 0
`define PSS_IRQ_LINK 1
`define PSS_IRQ_ENERGY 2
`define PSS_IRQ_DOWNGRADE 3
`define PSS_IRQ_BITS 4

`define PSS_CTRL_RESET 16'h1000
`define PSS_SW_RESET_CYCLES 4'h4
`endif

// ---- pkg/pss_pkg.sv ----
// types shared by the status bank modules
package pss_pkg;
  typedef struct packed {
    logic link_up;
    logic an_complete;
    logic mdix;
    logic downgrade;
    logic energy_sleep;
    logic tx_pause;
    logic rx_pause;
  } pss_link_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pss_apb_req_t;

  typedef struct packed {
    logic [1:0] xover_mode;
    logic an_enable;
  } pss_cfg_t;
endpackage

// ---- tb/pss_props.sv ----
// port checker for the status bank
`timescale 1ns/1ps
`include "pss_defines.svh"
module pss_props import pss_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // link and config
  input wire pss_link_t link,
  input wire logic auto_xover_mdix,
  input wire logic [1:0] xover_mode,
  input wire logic an_enable,
  input wire logic sw_reset_busy,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic rd0;
  logic wr_rst;
  logic [2:0] quiet;
  pss_link_t prev;
  assign rd0 = pready && !pwrite && paddr == `PSS_OFF_STATUS;
  assign wr_rst = psel && penable && pwrite && paddr == `PSS_OFF_CTRL && pwdata[15];
  // quiet: steady link, no soft reset; status lags so only judge settled reads
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev <= '0;
      quiet <= 3'h0;
    end else begin
      prev <= link;
      quiet <= (link != prev || sw_reset_busy) ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
    end
  end
  chk_rsv_zero: assert property (rd0 |-> prdata[9:7] == 3'h0)
    else $error("reserved status bits set");
  chk_xover_valid: assert property (rd0 && !prdata[11] |-> !prdata[6])
    else $error("crossover set while unresolved");
  chk_pause_valid: assert property (rd0 && !prdata[11] |-> prdata[3:2] == 2'h0)
    else $error("pause set while unresolved");
  chk_res_off: assert property (rd0 && quiet >= 3'h3 && !an_enable |-> prdata[11])
    else $error("resolved clear with negotiation off");
  chk_res_done: assert property (rd0 && quiet >= 3'h3 && link.an_complete |-> prdata[11])
    else $error("resolved clear after completion");
  chk_manual_xo: assert property (rd0 && quiet >= 3'h3 && prdata[11] && !xover_mode[1]
    |-> prdata[6] == xover_mode[0]) else $error("manual crossover wrong");
  chk_pause_copy: assert property (rd0 && quiet >= 3'h3 && prdata[11]
    |-> prdata[3:2] == {link.tx_pause, link.rx_pause}) else $error("pause copy wrong");
  // busy drops, apply strobe, latch, output register: the change shows three samples late
  chk_mode_hold: assert property ($changed(xover_mode) || $changed(an_enable)
    |-> $past(sw_reset_busy, 3)) else $error("config moved early");
  chk_busy_len: assert property ($rose(sw_reset_busy)
    |-> sw_reset_busy[*5] ##1 !sw_reset_busy) else $error("busy length wrong");
  chk_busy_cause: assert property ($rose(sw_reset_busy) |-> $past(wr_rst))
    else $error("busy without reset write");
  cov_busy: cover property ($rose(sw_reset_busy));
  cov_res: cover property (rd0 && prdata[11] && prdata[6]);
  cov_irq: cover property ($rose(irq));
endmodule

// ---- tb/tb_phy_specific_status_bits.sv ----
// self-checking bench for the status bank
`timescale 1ns/1ps
`include "pss_defines.svh"
module tb_phy_specific_status_bits import pss_pkg::*; ;
  logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, auto_xover_mdix, irq;
  logic an_enable, sw_reset_busy, en, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] xover_mode, mode;
  pss_link_t link;
  int n_fail, checks;
  pss_status_bank i_dut (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .link, .auto_xover_mdix, .xover_mode, .an_enable,
    .sw_reset_busy, .irq);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // ****************
  // tasks and model
  // ****************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // holds the request until pready; a missing answer ends the run
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      n_fail++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  function automatic logic [31:0] exp_stat();
    logic r;
    r = link.an_complete | ~en;
    return {20'h0, r, link.link_up, 3'h0, r & (mode[1] ? auto_xover_mdix : mode[0]),
      link.downgrade, link.energy_sleep, r & link.tx_pause, r & link.rx_pause, 2'h0};
  endfunction
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    link = '0;
    auto_xover_mdix = 1'b0;
    n_fail = 0;
    checks = 0;
    mode = 2'h0;
    en = 1'b1;
    void'($urandom(90884));
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    apb(1'b0, `PSS_OFF_CTRL, 32'h0);
    chk(rd, 32'h1000);
    apb(1'b0, `PSS_OFF_STATUS, 32'h0);
    chk(rd, exp_stat());
    // every crossover mode, negotiation on and off
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `PSS_OFF_CTRL, {19'h0, ~i[0], 5'h0, i[1:0], 5'h0});
      repeat (3) @(posedge ref_clk);
      chk(32'({an_enable, xover_mode}), 32'({en, mode}));
      apb(1'b1, `PSS_OFF_CTRL, {16'h0, 1'b1, 2'h0, ~i[0], 5'h0, i[1:0], 5'h0});
      mode = i[1:0];
      en = ~i[0];
      repeat (8) @(posedge ref_clk);
      chk(32'({sw_reset_busy, an_enable, xover_mode}), 32'({1'b0, en, mode}));
      repeat (4) begin
        link <= pss_link_t'(7'($urandom));
        auto_xover_mdix <= 1'($urandom);
        repeat (4) @(posedge ref_clk);
        apb(1'b0, `PSS_OFF_STATUS, 32'h0);
        chk(rd, exp_stat());
      end
    end
    apb(1'b1, `PSS_OFF_STATUS, 32'hffff_ffff);
    apb(1'b0, `PSS_OFF_STATUS, 32'h0);
    chk(rd, exp_stat());
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h0);
    chk(32'(er), 32'h1);
    // raw link inputs as seen by the bank
    apb(1'b0, `PSS_OFF_LINK_IN, 32'h0);
    chk(rd, {25'h0000000, link});
    // pause changes must raise nothing; link change must
    apb(1'b1, `PSS_OFF_IRQ_MASK, 32'hf);
    apb(1'b1, `PSS_OFF_IRQ_STAT, 32'hf);
    link <= link ^ 7'h03;
    repeat (4) @(posedge ref_clk);
    apb(1'b0, `PSS_OFF_IRQ_STAT, 32'h0);
    chk({rd[30:0], irq}, 32'h0);
    // link and energy both toggle: two flags, one interrupt
    link <= link ^ 7'h44;
    repeat (4) @(posedge ref_clk);
    apb(1'b0, `PSS_OFF_IRQ_STAT, 32'h0);
    chk({rd[30:0], irq}, 32'hd);
    apb(1'b1, `PSS_OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk(32'(irq), 32'h0);
    apb(1'b1, `PSS_OFF_IRQ_MASK, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk(32'(irq), 32'h1);
    apb(1'b1, `PSS_OFF_IRQ_STAT, 32'h6);
    repeat (2) @(posedge ref_clk);
    apb(1'b0, `PSS_OFF_IRQ_STAT, 32'h0);
    chk({rd[30:0], irq}, 32'h0);
    conclude();
  end
endmodule
bind pss_status_bank pss_props i_props (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .link, .auto_xover_mdix, .xover_mode, .an_enable,
  .sw_reset_busy, .irq);

// ---- verilog/pss_cfg_latch.sv ----
// crossover and negotiation settings that take effect on software reset
`timescale 1ns/1ps
`include "pss_defines.svh"
module pss_cfg_latch import pss_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // pending settings and apply strobe
  input pss_cfg_t pending,
  input wire logic apply,
  // active settings
  output pss_cfg_t active
);
  typedef struct packed {
    pss_cfg_t act;
  } pss_cl_state_t;

  pss_cl_state_t r, next_r;

  always_comb begin
    next_r = r;
    if (apply) begin
      next_r.act = pending;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '{act: '{xover_mode: 2'h0, an_enable: 1'b1}};
    end else begin
      r <= next_r;
    end
  end

  assign active = r.act;
endmodule

// ---- verilog/pss_irq.sv ----
// sticky event flags with write-one-to-clear and mask
`timescale 1ns/1ps
`include "pss_defines.svh"
module pss_irq import pss_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // events and software access
  input wire logic [`PSS_IRQ_BITS-1:0] event_in,
  input wire logic [`PSS_IRQ_BITS-1:0] clear_in,
  input wire logic mask_we,
  input wire logic [`PSS_IRQ_BITS-1:0] mask_in,
  // state
  output logic [`PSS_IRQ_BITS-1:0] status,
  output logic [`PSS_IRQ_BITS-1:0] mask,
  output logic irq
);
  typedef struct packed {
    logic [`PSS_IRQ_BITS-1:0] stat;
    logic [`PSS_IRQ_BITS-1:0] msk;
    logic irq;
  } pss_irq_state_t;

  pss_irq_state_t r, next_r;

  always_comb begin
    next_r = r;
    // set wins over a clear in the same cycle
    next_r.stat = (r.stat & ~clear_in) | event_in;
    if (mask_we) begin
      next_r.msk = mask_in;
    end
    next_r.irq = |(next_r.stat & next_r.msk);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign status = r.stat;
  assign mask = r.msk;
  assign irq = r.irq;
endmodule

// ---- verilog/pss_status_bank.sv ----
// specific status register bank with apb slave
//
// Behaviour
// - crossover status reads as valid only once the resolved bit is one.
// - resolved bit sets on negotiation complete, and whenever negotiation is disabled.
// - in manual mode crossover status follows software crossover control bits.
// - crossover control writes take effect only at a software reset.
// - transmit and receive pause bits copy the resolved pause result.
// - pause bits are informational; nothing inside acts on them.
// - pause bits are valid only after the resolved bit is set.
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "pss_defines.svh"
module pss_status_bank import pss_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link side state
  input pss_link_t link,
  input wire logic auto_xover_mdix,
  // active configuration toward link logic
  output logic [1:0] xover_mode,
  output logic an_enable,
  output logic sw_reset_busy,
  // interrupt
  output logic irq
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] status;
    logic [3:0] sw_cnt;
    logic busy;
    logic apply;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] xover_mode;
    logic an_enable;
    logic irq;
    logic prev_resolved;
    logic prev_link;
    logic prev_energy;
    logic prev_downgrade;
  } pss_bank_state_t;

  pss_bank_state_t r, next_r;

  pss_cfg_t pending_cfg;
  pss_cfg_t active_cfg;
  logic [`PSS_IRQ_BITS-1:0] irq_events;
  logic [`PSS_IRQ_BITS-1:0] irq_clear;
  logic [`PSS_IRQ_BITS-1:0] irq_status;
  logic [`PSS_IRQ_BITS-1:0] irq_mask;
  logic irq_level;
  logic mask_we;
  logic acc;
  logic wr;
  logic rd;
  logic mapped;

  // ****************************************
  // apb decode
  // ****************************************
  // one wait state per access: pready is registered and rises the cycle after the first access cycle
  assign acc = psel & penable & ~r.pready;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign mapped = (paddr == `PSS_OFF_STATUS) || (paddr == `PSS_OFF_CTRL) ||
                  (paddr == `PSS_OFF_IRQ_STAT) || (paddr == `PSS_OFF_IRQ_MASK) ||
                  (paddr == `PSS_OFF_LINK_IN);
  assign mask_we = wr && (paddr == `PSS_OFF_IRQ_MASK);
  assign irq_clear = (wr && (paddr == `PSS_OFF_IRQ_STAT)) ?
                     pwdata[`PSS_IRQ_BITS-1:0] : '0;

  assign pending_cfg.xover_mode = r.ctrl[`PSS_CTRL_XOVER_HI:`PSS_CTRL_XOVER_LO];
  assign pending_cfg.an_enable = r.ctrl[`PSS_CTRL_AN_ENABLE];

  // ****************************************
  // submodules
  // ****************************************
  pss_cfg_latch u_cfg (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pending(pending_cfg),
    .apply(r.apply),
    .active(active_cfg)
  );

  pss_irq u_irq (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .event_in(irq_events),
    .clear_in(irq_clear),
    .mask_we(mask_we),
    .mask_in(pwdata[`PSS_IRQ_BITS-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq_level)
  );

  // events: rising edges of resolved and downgrade, any change of link and energy in the composed status
  always_comb begin
    irq_events = '0;
    irq_events[`PSS_IRQ_RESOLVED] = r.status[`PSS_BIT_RESOLVED] & ~r.prev_resolved;
    irq_events[`PSS_IRQ_LINK] = r.status[`PSS_BIT_LINK] ^ r.prev_link;
    irq_events[`PSS_IRQ_ENERGY] = r.status[`PSS_BIT_ENERGY] ^ r.prev_energy;
    irq_events[`PSS_IRQ_DOWNGRADE] = r.status[`PSS_BIT_DOWNGRADE] & ~r.prev_downgrade;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic resolved;
    resolved = 1'b0;
    next_r = r;
    next_r.apply = 1'b0;
    next_r.pready = acc;
    next_r.pslverr = acc & ~mapped;
    next_r.prdata = '0;

    // software reset sequence: hold busy a few cycles, then apply settings
    if (r.busy) begin
      if (r.sw_cnt == 4'h0) begin
        next_r.busy = 1'b0;
        next_r.apply = 1'b1;
        next_r.ctrl[`PSS_CTRL_SW_RESET] = 1'b0;
      end else begin
        next_r.sw_cnt = r.sw_cnt - 4'h1;
      end
    end

    if (wr && (paddr == `PSS_OFF_CTRL)) begin
      // crossover bits are only stored here, not applied
      next_r.ctrl = pwdata[15:0];
      if (pwdata[`PSS_CTRL_SW_RESET]) begin
        next_r.busy = 1'b1;
        next_r.sw_cnt = `PSS_SW_RESET_CYCLES;
      end else begin
        next_r.ctrl[`PSS_CTRL_SW_RESET] = r.ctrl[`PSS_CTRL_SW_RESET];
      end
    end

    // compose status; software cannot write it
    resolved = link.an_complete | ~active_cfg.an_enable;
    next_r.status = '0;
    next_r.status[`PSS_BIT_RESOLVED] = resolved;
    next_r.status[`PSS_BIT_LINK] = link.link_up;
    // before resolution the crossover bit is held at zero as meaningless
    if (resolved) begin
      if (active_cfg.xover_mode == `PSS_XOVER_MANUAL_MDI) begin
        next_r.status[`PSS_BIT_XOVER] = 1'b0;
      end else if (active_cfg.xover_mode == `PSS_XOVER_MANUAL_MDIX) begin
        next_r.status[`PSS_BIT_XOVER] = 1'b1;
      end else begin
        next_r.status[`PSS_BIT_XOVER] = auto_xover_mdix;
      end
      // pause bits are mirrored only; no internal logic reads them
      next_r.status[`PSS_BIT_TX_PAUSE] = link.tx_pause;
      next_r.status[`PSS_BIT_RX_PAUSE] = link.rx_pause;
    end
    next_r.status[`PSS_BIT_DOWNGRADE] = link.downgrade;
    next_r.status[`PSS_BIT_ENERGY] = link.energy_sleep;
    // software reset clears the soft-reset-sensitive fields
    if (r.busy) begin
      next_r.status[`PSS_BIT_XOVER] = 1'b0;
      next_r.status[`PSS_BIT_TX_PAUSE] = 1'b0;
      next_r.status[`PSS_BIT_RX_PAUSE] = 1'b0;
    end

    next_r.prev_resolved = r.status[`PSS_BIT_RESOLVED];
    next_r.prev_link = r.status[`PSS_BIT_LINK];
    next_r.prev_energy = r.status[`PSS_BIT_ENERGY];
    next_r.prev_downgrade = r.status[`PSS_BIT_DOWNGRADE];

    if (rd) begin
      unique case (paddr)
        `PSS_OFF_STATUS: next_r.prdata = {16'h0000, r.status};
        `PSS_OFF_CTRL: next_r.prdata = {16'h0000, r.ctrl};
        `PSS_OFF_IRQ_STAT: next_r.prdata = {28'h0000000, irq_status};
        `PSS_OFF_IRQ_MASK: next_r.prdata = {28'h0000000, irq_mask};
        `PSS_OFF_LINK_IN: next_r.prdata = {25'h0000000, link};
        default: next_r.prdata = 32'h00000000;
      endcase
    end

    next_r.xover_mode = active_cfg.xover_mode;
    next_r.an_enable = active_cfg.an_enable;
    next_r.irq = irq_level;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
      r.ctrl <= `PSS_CTRL_RESET;
      r.an_enable <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign xover_mode = r.xover_mode;
  assign an_enable = r.an_enable;
  assign sw_reset_busy = r.busy;
  assign irq = r.irq;
endmodule
